// File: rtl/paired_timers.sv
// What this block does
// - Timer A counts up 0000h to FFFFh, then wraps to zero.
// - Timer A wrap sets flag one bit 0; interrupt only with enable bit.
// - Special-event compare match on timer A's unit resets timer A.
// - Unit two's special event also starts a conversion if converter enabled.
// - Special reset only trusted in timer or synchronous counter mode.
// - Compare value acts as the timer period under special reset.
// - Software write in the same cycle as special reset wins.
// - Special reset never sets the overflow flag.
// - Timer B control bit 7 picks buffered 16-bit or byte access.
// - Timebase select routes timer A or B to each compare unit.
// - Timer B prescale codes divide by 1, 2, 4 or 8.
// - Sync bypass bit matters only with external clock selected.
// - External clock counts rising edges, only after a falling edge.
// - Run bit starts counting; cleared it freezes the count.
// - Buffered mode: low read copies live high byte into buffer.
// - Buffered mode: high write fills buffer; low write loads both.
// - Timer A counts instruction clock or external edges per select.
// - Timer B wraps and latches overflow in flag two bit 1.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module paired_timers (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_pin,
    input wire logic timer_osc_level,
    input wire logic system_clock_from_timer_osc,
    input wire logic adc_enabled,
    output logic timer_osc_enable,
    output logic timer_a_irq,
    output logic timer_b_irq,
    output logic adc_start
);
    import timer_pkg::*;

    logic [7:0] ctrl [2];
    logic [7:0] hbuf [2];
    logic [15:0] count [2];
    logic [15:0] load_val [2];
    logic [15:0] cmp_val [2];
    logic [15:0] base [2];
    logic load [2];
    logic wrap [2];
    logic evt [2];
    logic trig [2];
    logic on_b [2];
    logic eq_d [2];
    logic [7:0] cmp_mode;
    logic [1:0] timebase;
    logic flag_a;
    logic flag_b;
    logic en_a;
    logic en_b;
    logic wr;
    logic rd;
    logic hit;
    logic [31:0] next_prdata;
    logic ext_level;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pslverr = psel && penable && !hit;

    assign timebase = {ctrl[1][BIT_TB_HI], ctrl[1][BIT_TB_LO]};
    assign on_b[0] = timebase[1];
    assign on_b[1] = (timebase != TB_BOTH_A);
    assign timer_osc_enable = ctrl[0][BIT_OSC_EN];
    // Both timers share the oscillator or the pin, never a mix
    assign ext_level = timer_osc_enable ? timer_osc_level : external_count_pin;

    // ------------------------------------------------------------
    // Per timer and per compare unit
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_tmr
        localparam logic [7:0] LOW = (i == 0) ? OFF_A_LOW : OFF_B_LOW;
        localparam logic [7:0] HIGH = (i == 0) ? OFF_A_HIGH : OFF_B_HIGH;
        localparam logic [7:0] CTRL = (i == 0) ? OFF_A_CTRL : OFF_B_CTRL;
        logic wide;
        logic wr_low;
        logic wr_high;
        timer_cfg_t cfg;

        assign wide = ctrl[i][BIT_WIDE];
        assign wr_low = wr && (paddr == LOW);
        assign wr_high = wr && (paddr == HIGH);
        assign load[i] = wr_low || (wr_high && !wide);
        assign load_val[i] = !wr_low ? {pwdata[7:0], count[i][7:0]} :
            wide ? {hbuf[i], pwdata[7:0]} : {count[i][15:8], pwdata[7:0]};
        assign cfg = '{run: ctrl[i][BIT_RUN], clock_select: ctrl[i][BIT_CLK_SEL],
            sync_bypass: ctrl[i][BIT_SYNC_BYP], prescale: ctrl[i][BIT_PS_HI:BIT_PS_LO]};

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctrl[i] <= CTRL_RESET;
            end else if (ce && wr && (paddr == CTRL)) begin
                // Timer A bit 6 is a status bit, never stored
                ctrl[i] <= (i == 0) ? (pwdata[7:0] & 8'hbf) : pwdata[7:0];
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                hbuf[i] <= 8'h00;
            end else if (ce) begin
                if (wr_high && wide) begin
                    hbuf[i] <= pwdata[7:0];
                end else if (rd && (paddr == LOW) && wide) begin
                    hbuf[i] <= count[i][15:8];
                end
            end
        end

        timer_core u_core (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .cfg(cfg),
            .ext_level(ext_level),
            .load(load[i]),
            .load_value(load_val[i]),
            .clear_prescale(wr_low || (wr_high && !wide)),
            .event_reset(evt[i]),
            .count(count[i]),
            .wrap(wrap[i])
        );

        // Compare unit i: one trigger per arrival at the compare value
        assign base[i] = on_b[i] ? count[1] : count[0];
        assign trig[i] = (cmp_mode[i*4 +: 4] == CMP_SPECIAL) &&
            (base[i] == cmp_val[i]) && !eq_d[i];

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                eq_d[i] <= 1'b0;
            end else if (ce) begin
                eq_d[i] <= (base[i] == cmp_val[i]);
            end
        end
    end

    // Async counter mode may miss this reset; software must avoid it
    assign evt[0] = (trig[0] && !on_b[0]) || (trig[1] && !on_b[1]);
    assign evt[1] = (trig[0] && on_b[0]) || (trig[1] && on_b[1]);

    // ------------------------------------------------------------
    // Compare configuration
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_mode <= CMP_MODE_RESET;
            cmp_val[0] <= CMP_VAL_RESET;
            cmp_val[1] <= CMP_VAL_RESET;
        end else if (ce && wr) begin
            if (paddr == OFF_CMP_MODE) begin
                cmp_mode <= pwdata[7:0];
            end
            if (paddr == OFF_CMP_VAL_ONE) begin
                cmp_val[0] <= pwdata[15:0];
            end
            if (paddr == OFF_CMP_VAL_TWO) begin
                cmp_val[1] <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_start <= 1'b0;
        end else if (ce) begin
            adc_start <= trig[1] && adc_enabled;
        end
    end

    // ------------------------------------------------------------
    // Overflow flags and enables
    // ------------------------------------------------------------
    // A wrap in the clearing cycle still sets the flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_a <= 1'b0;
            flag_b <= 1'b0;
        end else if (ce) begin
            flag_a <= wrap[0] || ((wr && paddr == OFF_FLAGS_ONE) ? pwdata[FLAG_A_BIT] : flag_a);
            flag_b <= wrap[1] || ((wr && paddr == OFF_FLAGS_TWO) ? pwdata[FLAG_B_BIT] : flag_b);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_a <= 1'b0;
            en_b <= 1'b0;
        end else if (ce && wr) begin
            if (paddr == OFF_ENABLES_ONE) begin
                en_a <= pwdata[FLAG_A_BIT];
            end
            if (paddr == OFF_ENABLES_TWO) begin
                en_b <= pwdata[FLAG_B_BIT];
            end
        end
    end

    assign timer_a_irq = flag_a && en_a;
    assign timer_b_irq = flag_b && en_b;

    // ------------------------------------------------------------
    // Read path: data is captured in the setup cycle
    // ------------------------------------------------------------
    always_comb begin
        next_prdata = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            OFF_A_LOW: next_prdata[7:0] = count[0][7:0];
            OFF_A_HIGH: next_prdata[7:0] = ctrl[0][BIT_WIDE] ? hbuf[0] : count[0][15:8];
            OFF_A_CTRL: begin
                next_prdata[7:0] = ctrl[0];
                next_prdata[BIT_SYSCLK] = system_clock_from_timer_osc;
            end
            OFF_B_LOW: next_prdata[7:0] = count[1][7:0];
            OFF_B_HIGH: next_prdata[7:0] = ctrl[1][BIT_WIDE] ? hbuf[1] : count[1][15:8];
            OFF_B_CTRL: next_prdata[7:0] = ctrl[1];
            OFF_FLAGS_ONE: next_prdata[FLAG_A_BIT] = flag_a;
            OFF_ENABLES_ONE: next_prdata[FLAG_A_BIT] = en_a;
            OFF_FLAGS_TWO: next_prdata[FLAG_B_BIT] = flag_b;
            OFF_ENABLES_TWO: next_prdata[FLAG_B_BIT] = en_b;
            OFF_CMP_MODE: next_prdata[7:0] = cmp_mode;
            OFF_CMP_VAL_ONE: next_prdata[15:0] = cmp_val[0];
            OFF_CMP_VAL_TWO: next_prdata[15:0] = cmp_val[1];
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            prdata <= next_prdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    wrap_to_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        wrap[0] |-> count[0] == COUNT_RESET) else $error("timer A wrap not at zero");
    flag_a_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        wrap[0] && ce |=> flag_a) else $error("timer A flag not set by wrap");
    irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        timer_a_irq |-> en_a && flag_a) else $error("timer A irq without enable");
    event_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && evt[0] && !load[0] |=> count[0] == COUNT_RESET) else $error("special reset lost");
    write_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && evt[0] && load[0] |=> count[0] == $past(load_val[0]))
        else $error("special reset beat write");
    no_event_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && evt[0] |=> !wrap[0]) else $error("special reset raised overflow");
    adc_trigger_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && trig[1] && adc_enabled |=> adc_start) else $error("conversion not started");
    frozen_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !ctrl[1][BIT_RUN] && !load[1] && !evt[1] |=> $stable(count[1]))
        else $error("stopped timer B moved");
    buffer_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && rd && paddr == OFF_B_LOW && ctrl[1][BIT_WIDE] |=> hbuf[1] == $past(count[1][15:8]))
        else $error("high byte not buffered");
    route_both_a: assert property (@(posedge pclk) disable iff (!presetn)
        timebase == TB_BOTH_A |-> !on_b[0] && !on_b[1]) else $error("timebase routing wrong");
    flag_b_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        wrap[1] && ce |=> flag_b) else $error("timer B flag not set by wrap");
    flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wr && paddr == OFF_FLAGS_ONE && !pwdata[FLAG_A_BIT] && !wrap[0] |=> !flag_a)
        else $error("timer A flag not cleared");
    wide_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && load[1] && ctrl[1][BIT_WIDE]
        |=> count[1] == {$past(hbuf[1]), $past(pwdata[7:0])}) else $error("wide write not loaded");
    high_buffer_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wr && paddr == OFF_B_HIGH && ctrl[1][BIT_WIDE] && !ctrl[1][BIT_RUN] && !evt[1]
        |=> $stable(count[1]) && hbuf[1] == $past(pwdata[7:0]))
        else $error("high write reached the count");
    // Clock enable low must hold both counts, the read data and flag A
    ce_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ce |=> $stable(count[0]) && $stable(count[1]) && $stable(prdata) && $stable(flag_a))
        else $error("state moved with clock enable low");

    wrap_a_c: cover property (@(posedge pclk) disable iff (!presetn) wrap[0]);
    wrap_b_c: cover property (@(posedge pclk) disable iff (!presetn) wrap[1]);
    event_c: cover property (@(posedge pclk) disable iff (!presetn) evt[0] ##[1:100] evt[0]);
    split_route_c: cover property (@(posedge pclk) disable iff (!presetn) on_b[1] && !on_b[0]);
    adc_c: cover property (@(posedge pclk) disable iff (!presetn) adc_start);
endmodule
`default_nettype wire

// File: rtl/timer_pkg.sv
package timer_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_A_LOW = 8'h00;
    localparam logic [7:0] OFF_A_HIGH = 8'h04;
    localparam logic [7:0] OFF_A_CTRL = 8'h08;
    localparam logic [7:0] OFF_B_LOW = 8'h0c;
    localparam logic [7:0] OFF_B_HIGH = 8'h10;
    localparam logic [7:0] OFF_B_CTRL = 8'h14;
    localparam logic [7:0] OFF_FLAGS_ONE = 8'h18;
    localparam logic [7:0] OFF_ENABLES_ONE = 8'h1c;
    localparam logic [7:0] OFF_FLAGS_TWO = 8'h20;
    localparam logic [7:0] OFF_ENABLES_TWO = 8'h24;
    localparam logic [7:0] OFF_CMP_MODE = 8'h28;
    localparam logic [7:0] OFF_CMP_VAL_ONE = 8'h2c;
    localparam logic [7:0] OFF_CMP_VAL_TWO = 8'h30;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int BIT_WIDE = 7;
    localparam int BIT_SYSCLK = 6;
    localparam int BIT_TB_HI = 6;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_OSC_EN = 3;
    localparam int BIT_TB_LO = 3;
    localparam int BIT_SYNC_BYP = 2;
    localparam int BIT_CLK_SEL = 1;
    localparam int BIT_RUN = 0;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_B_BIT = 1;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CMP_MODE_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] CMP_VAL_RESET = 16'hffff;
    localparam logic [3:0] CMP_SPECIAL = 4'hb;
    localparam logic [1:0] TB_BOTH_A = 2'h0;
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV2 = 2'h1;
    localparam logic [1:0] PS_DIV4 = 2'h2;
    localparam logic [2:0] PRE_RESET = 3'h0;

    typedef struct packed {
        logic run;
        logic clock_select;
        logic sync_bypass;
        logic [1:0] prescale;
    } timer_cfg_t;
endpackage

// File: rtl/timer_core.sv
`timescale 1ns/100ps
`default_nettype none
module timer_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire timer_pkg::timer_cfg_t cfg,
    input wire logic ext_level,
    input wire logic load,
    input wire logic [15:0] load_value,
    input wire logic clear_prescale,
    input wire logic event_reset,
    output logic [15:0] count,
    output logic wrap
);
    import timer_pkg::*;

    logic ext_sync;
    logic ext_prev;
    logic seen_fall;
    logic [2:0] pre;
    logic [2:0] mask;
    logic edge_src;
    logic tick;
    logic inc;

    // ------------------------------------------------------------
    // Count clock selection
    // ------------------------------------------------------------
    assign edge_src = cfg.sync_bypass ? ext_level : ext_sync;
    // Internal source counts every instruction cycle
    assign tick = cfg.clock_select ? (edge_src & ~ext_prev & seen_fall) : 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else if (ce) begin
            ext_sync <= ext_level;
            ext_prev <= edge_src;
        end
    end

    // A high pin at select time must not count: wait for a fall first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_fall <= 1'b0;
        end else if (ce) begin
            if (!cfg.clock_select) begin
                seen_fall <= 1'b0;
            end else if (ext_prev && !edge_src) begin
                seen_fall <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    always_comb begin
        case (cfg.prescale)
            PS_DIV1: mask = 3'h0;
            PS_DIV2: mask = 3'h1;
            PS_DIV4: mask = 3'h3;
            default: mask = 3'h7;
        endcase
    end

    assign inc = cfg.run && tick && ((pre & mask) == mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= PRE_RESET;
        end else if (ce) begin
            if (clear_prescale) begin
                pre <= PRE_RESET;
            end else if (cfg.run && tick) begin
                pre <= pre + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Counter: write beats special reset beats increment
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= COUNT_RESET;
        end else if (ce) begin
            if (load) begin
                count <= load_value;
            end else if (event_reset) begin
                count <= COUNT_RESET;
            end else if (inc) begin
                count <= count + 16'h0001;
            end
        end
    end

    // A special reset is not a wrap, so it raises no overflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wrap <= 1'b0;
        end else if (ce) begin
            wrap <= inc && !load && !event_reset && (count == COUNT_MAX);
        end
    end
endmodule
`default_nettype wire

// File: sim/count_source.sv
`timescale 1ns/100ps
`default_nettype none
module count_source (
    input wire logic pclk,
    output logic external_count_pin,
    output logic timer_osc_level
);
    // Lines idle high, so the first edge after a select is a fall
    initial begin
        external_count_pin = 1'b1;
        timer_osc_level = 1'b1;
    end

    // Slow pulses keep each level well past the sync delay
    task automatic pulses(input int n, input logic use_osc);
        repeat (n) begin
            repeat (4) @(posedge pclk);
            if (use_osc)
                timer_osc_level <= 1'b0;
            else
                external_count_pin <= 1'b0;
            repeat (4) @(posedge pclk);
            if (use_osc)
                timer_osc_level <= 1'b1;
            else
                external_count_pin <= 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// File: sim/paired_16bit_timer_counters_test.sv
`timescale 1ns/100ps
`default_nettype none
module paired_16bit_timer_counters_test;
    import timer_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
    logic pready, pslverr, rerr, ext_pin, osc_lvl, osc_en, irq_a, irq_b, adc_start;
    logic sys_osc = 1'b0, adc_on = 1'b1;
    logic [7:0] lo_of[2] = '{OFF_A_LOW, OFF_B_LOW};
    logic [7:0] hi_of[2] = '{OFF_A_HIGH, OFF_B_HIGH};
    logic [7:0] ctl_of[2] = '{OFF_A_CTRL, OFF_B_CTRL};
    logic [7:0] flg_of[2] = '{OFF_FLAGS_ONE, OFF_FLAGS_TWO};
    logic [7:0] ena_of[2] = '{OFF_ENABLES_ONE, OFF_ENABLES_TWO};
    int bad_count = 0, n_tests = 0, pulses = 0, p0;

    always #25 pclk = ~pclk;
    always @(posedge pclk) if (adc_start === 1'b1) pulses <= pulses + 1;

    count_source i_src (.pclk(pclk), .external_count_pin(ext_pin), .timer_osc_level(osc_lvl));
    paired_timers i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_count_pin(ext_pin),
        .timer_osc_level(osc_lvl), .system_clock_from_timer_osc(sys_osc),
        .adc_enabled(adc_on), .timer_osc_enable(osc_en), .timer_a_irq(irq_a),
        .timer_b_irq(irq_b), .adc_start(adc_start));

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 16'h0000);
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Start and stop land a cycle or two apart from the nominal span
    task automatic check_near(input string what, input int exp, input logic [31:0] got);
        n_tests++;
        if (^got === 1'bx || int'(got) > exp + 2 || int'(got) + 2 < exp) begin
            bad_count++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge pclk);
        bad_count++;
        complete_run;
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_A_CTRL);
        check("a_ctrl reset", 32'h0000_0000, rdata);
        rd(OFF_B_CTRL);
        check("b_ctrl reset", 32'h0000_0000, rdata);
        rd(OFF_CMP_VAL_TWO);
        check("cmp two reset", 32'h0000_ffff, rdata);
        rd(8'h3c);
        check("unmapped error", 32'h0000_0001, {31'h0, rerr});
        sys_osc <= 1'b1;
        rd(OFF_A_CTRL);
        check("a_ctrl status", 32'h0000_0040, rdata);
        sys_osc <= 1'b0;
        for (int t = 0; t < 2; t++) begin
            wr(ena_of[t], 16'(1 << t));
            wr(hi_of[t], 16'h00ff);
            wr(lo_of[t], 16'h00fd);
            wr(ctl_of[t], 16'h0001);
            repeat (10) @(posedge pclk);
            wr(ctl_of[t], 16'h0000);
            rd(flg_of[t]);
            check("overflow flag", 32'(1 << t), rdata);
            check("irq", 32'h0000_0001, {31'h0, (t == 0) ? irq_a : irq_b});
            rd(lo_of[t]);
            check_near("low after wrap", 10, rdata);
            rd(hi_of[t]);
            check("high after wrap", 32'h0000_0000, rdata);
            wr(flg_of[t], 16'h0000);
        end
        for (int c = 0; c < 4; c++) begin
            wr(OFF_B_LOW, 16'h0000);
            wr(OFF_B_CTRL, 16'((c << 4) | 1));
            repeat (62) @(posedge pclk);
            wr(OFF_B_CTRL, 16'h0000);
            rd(OFF_B_LOW);
            check_near("prescaled count", 64 >> c, rdata);
        end
        wr(OFF_B_LOW, 16'h0000);
        wr(OFF_B_CTRL, 16'h0001);
        ce <= 1'b0;
        repeat (20) @(posedge pclk);
        ce <= 1'b1;
        wr(OFF_B_CTRL, 16'h0000);
        rd(OFF_B_LOW);
        check("frozen by ce", 32'h0000_0003, rdata);
        wr(OFF_B_CTRL, 16'h0080);
        wr(OFF_B_HIGH, 16'h005a);
        wr(OFF_B_CTRL, 16'h0000);
        rd(OFF_B_HIGH);
        check("live high kept", 32'h0000_0000, rdata);
        wr(OFF_B_CTRL, 16'h0080);
        wr(OFF_B_LOW, 16'h00c3);
        wr(OFF_B_CTRL, 16'h0000);
        rd(OFF_B_HIGH);
        check("high loaded", 32'h0000_005a, rdata);
        rd(OFF_B_LOW);
        check("low loaded", 32'h0000_00c3, rdata);
        wr(OFF_B_HIGH, 16'h0077);
        wr(OFF_B_CTRL, 16'h0080);
        rd(OFF_B_LOW);
        rd(OFF_B_HIGH);
        check("buffered high", 32'h0000_0077, rdata);
        for (int k = 0; k < 3; k++) begin
            wr(OFF_A_LOW, 16'h0000);
            wr(OFF_A_HIGH, (k == 2) ? 16'h0080 : 16'h0000);
            wr(OFF_A_CTRL, 16'((k == 1 ? 4 : 0) | (k == 2 ? 12 : 0) | 3));
            i_src.pulses(5, k == 2);
            repeat (6) @(posedge pclk);
            check("osc enable", 32'(k == 2), {31'h0, osc_en});
            wr(OFF_A_CTRL, 16'h0000);
            rd(OFF_A_LOW);
            check("external count", 32'h0000_0005, rdata);
            rd(OFF_A_HIGH);
            check("high preload", (k == 2) ? 32'h0000_0080 : 32'h0000_0000, rdata);
        end
        wr(OFF_A_HIGH, 16'h0000);
        wr(OFF_CMP_VAL_TWO, 16'h0010);
        wr(OFF_CMP_MODE, 16'h00b0);
        wr(OFF_A_CTRL, 16'h0001);
        for (int s = 0; s < 4; s++) begin
            wr(OFF_A_LOW, 16'h0000);
            wr(OFF_B_CTRL, 16'(((s >> 1) << 6) | ((s & 1) << 3)));
            p0 = pulses;
            repeat (80) @(posedge pclk);
            rd(OFF_A_LOW);
            check("held to period", 32'(s == 0), 32'(rdata <= 32'h0000_0010));
            check("conversion start", 32'(s == 0), 32'(pulses > p0));
        end
        rd(OFF_FLAGS_ONE);
        check("no flag on event", 32'h0000_0000, rdata);
        wr(OFF_A_CTRL, 16'h0000);
        complete_run;
    end
endmodule
`default_nettype wire
